/* File: verilog/rctr_pkg.sv */
package rctr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TOL_TAP1 = 8'h35;
    localparam logic [7:0] ADDR_EYE_REF = 8'h36;
    localparam logic [7:0] ADDR_LEQ_STAT = 8'h37;
    localparam logic [7:0] ADDR_FEQ_STAT = 8'h38;
    localparam logic [7:0] ADDR_ERR_LO = 8'h3B;
    localparam logic [7:0] ADDR_ERR_HI = 8'h3C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hF0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hF1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TOL_SCALE_LSB = 6;
    localparam int SNAP_BIT = 5;
    localparam int TAP1_LSB = 0;
    localparam int EYE_IRQ_EN_BIT = 6;
    localparam int REF_MODE_LSB = 4;
    localparam int RNG_OV_BIT = 2;
    localparam int RNG_LSB = 0;
    localparam int IRQ_SNAP_BIT = 0;
    localparam int IRQ_EYE_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TOL_TAP1 = 8'h1F;
    localparam logic [7:0] RST_EYE_REF = 8'h31;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // lock_tolerance_and_tap1_limit writable bits (snapshot bit handled separately)
    localparam logic [7:0] MASK_TOL_TAP1 = 8'hDF;
    // eye_irq_and_lock_reference_control reserved bits 7 and 3 read as zero
    localparam logic [7:0] MASK_EYE_REF = 8'h77;

    typedef enum logic [1:0] {
        RCTR_REF_FREE_FULL,
        RCTR_REF_FREE_NARROW,
        RCTR_REF_CLK_NARROW,
        RCTR_REF_CLK_FAST
    } rctr_ref_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rctr_bus_req_t;

    typedef struct packed {
        logic [8:0] tol_scaled;
        logic [4:0] tap1_limit;
        logic eye_irq_enable;
        rctr_ref_mode_t ref_mode;
        logic range_override;
        logic [4:0] stop_value;
    } rctr_cfg_t;

endpackage

/* File: verilog/rctr_regs.sv */
// How it works
// RULE1: scale code widens the tolerance from 0x64
// RULE2: snapshot bit captures error, then self-clears
// RULE3: error result updates continuously without trigger
// RULE4: tap1 limit field, resets all ones
// RULE5: eye-opening interrupt only when enabled
// RULE6: reference mode selects lock method, resets 11
// RULE7: override bit picks register range over default
// RULE8: stop equals start minus field plus one
// RULE9: equalizer status bytes read-only, reset zero
// RULE10: software writes reserved bits as zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module rctr_regs #(
    parameter int ERR_W = 16,
    parameter logic [4:0] DEFAULT_RANGE = 5'h02
) (
    input wire logic clock,
    input wire logic srst,
    input wire rctr_pkg::rctr_bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic [7:0] tol_base,
    input wire logic [4:0] range_start,
    input wire logic [ERR_W-1:0] ppm_count,
    input wire logic eye_fail,
    input wire logic [7:0] leq_status,
    input wire logic [7:0] feq_status,
    output rctr_pkg::rctr_cfg_t cfg,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] tol_tap1;
        logic [7:0] eye_ref;
        logic snap_pend;
        logic [ERR_W-1:0] err;
        logic [7:0] leq;
        logic [7:0] feq;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] rdata;
        rctr_pkg::rctr_cfg_t cfg;
        logic irq;
    } rctr_state_t;

    rctr_state_t s_q;
    rctr_state_t s_d;

    logic [8:0] tol_calc;
    logic [4:0] stop_calc;
    logic [1:0] scale;
    logic [1:0] rng;
    logic [1:0] ev;
    logic [1:0] stat_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        scale = s_q.tol_tap1[rctr_pkg::TOL_SCALE_LSB +: 2];
        rng = s_q.eye_ref[rctr_pkg::RNG_LSB +: 2];
        // RULE1: tolerance scaling
        unique case (scale)
            2'h0: tol_calc = {1'b0, tol_base};
            2'h1: tol_calc = {1'b0, tol_base} + {6'h00, tol_base[3:1]};
            2'h2: tol_calc = {tol_base, 1'b0};
            2'h3: tol_calc = {tol_base, 1'b0} + {6'h00, tol_base[3:1]};
        endcase
        // RULE8: stop value below start
        stop_calc = range_start - ({3'h0, rng} + 5'h01);

        ev = 2'h0;
        // RULE3: continuous update
        if (!s_q.snap_pend) begin
            s_d.err = ppm_count;
        end
        // RULE2: capture then self-clear
        if (s_q.snap_pend) begin
            s_d.err = ppm_count;
            s_d.snap_pend = 1'b0;
            ev[rctr_pkg::IRQ_SNAP_BIT] = 1'b1;
        end
        // RULE5: eye event gated by enable
        ev[rctr_pkg::IRQ_EYE_BIT] = eye_fail & s_q.eye_ref[rctr_pkg::EYE_IRQ_EN_BIT];

        // RULE9: status mirrors, no write path
        s_d.leq = leq_status;
        s_d.feq = feq_status;

        stat_next = s_q.irq_stat;
        if (bus.wr) begin
            unique case (bus.addr)
                rctr_pkg::ADDR_TOL_TAP1: begin
                    // RULE4: tap1 limit writable
                    s_d.tol_tap1 = bus.wdata & rctr_pkg::MASK_TOL_TAP1;
                    if (bus.wdata[rctr_pkg::SNAP_BIT]) begin
                        s_d.snap_pend = 1'b1;
                    end
                end
                // RULE10: reserved bits dropped
                rctr_pkg::ADDR_EYE_REF: s_d.eye_ref = bus.wdata & rctr_pkg::MASK_EYE_REF;
                rctr_pkg::ADDR_IRQ_STAT: stat_next = s_q.irq_stat & ~bus.wdata[1:0];
                rctr_pkg::ADDR_IRQ_MASK: s_d.irq_mask = bus.wdata[1:0];
                default: ;
            endcase
        end
        // set wins over clear
        s_d.irq_stat = stat_next | ev;

        s_d.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                rctr_pkg::ADDR_TOL_TAP1:
                    s_d.rdata = s_q.tol_tap1 | {2'h0, s_q.snap_pend, 5'h00};
                rctr_pkg::ADDR_EYE_REF: s_d.rdata = s_q.eye_ref;
                rctr_pkg::ADDR_LEQ_STAT: s_d.rdata = s_q.leq;
                rctr_pkg::ADDR_FEQ_STAT: s_d.rdata = s_q.feq;
                rctr_pkg::ADDR_ERR_LO: s_d.rdata = s_q.err[7:0];
                rctr_pkg::ADDR_ERR_HI: s_d.rdata = s_q.err[15:8];
                rctr_pkg::ADDR_IRQ_STAT: s_d.rdata = {6'h00, s_q.irq_stat};
                rctr_pkg::ADDR_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
                default: s_d.rdata = 8'h00;
            endcase
        end

        s_d.cfg.tol_scaled = tol_calc;
        s_d.cfg.tap1_limit = s_q.tol_tap1[rctr_pkg::TAP1_LSB +: 5];
        s_d.cfg.eye_irq_enable = s_q.eye_ref[rctr_pkg::EYE_IRQ_EN_BIT];
        // RULE6: lock method select
        s_d.cfg.ref_mode = rctr_pkg::rctr_ref_mode_t'(s_q.eye_ref[rctr_pkg::REF_MODE_LSB +: 2]);
        s_d.cfg.range_override = s_q.eye_ref[rctr_pkg::RNG_OV_BIT];
        // RULE7: override selects range source
        s_d.cfg.stop_value = s_q.eye_ref[rctr_pkg::RNG_OV_BIT] ? stop_calc
                                                                : range_start - DEFAULT_RANGE;
        s_d.irq = |(s_q.irq_stat & s_q.irq_mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
            s_q.tol_tap1 <= rctr_pkg::RST_TOL_TAP1;
            s_q.eye_ref <= rctr_pkg::RST_EYE_REF;
            s_q.leq <= rctr_pkg::RST_STATUS;
            s_q.feq <= rctr_pkg::RST_STATUS;
            s_q.irq_stat <= rctr_pkg::RST_IRQ;
            s_q.irq_mask <= rctr_pkg::RST_IRQ;
            s_q.cfg.tap1_limit <= rctr_pkg::RST_TOL_TAP1[rctr_pkg::TAP1_LSB +: 5];
            s_q.cfg.ref_mode <= rctr_pkg::RCTR_REF_CLK_FAST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign cfg = s_q.cfg;
    assign irq = s_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_snap_clears;
        @(posedge clock) disable iff (srst)
        (bus.wr && bus.addr == rctr_pkg::ADDR_TOL_TAP1 && bus.wdata[5]) |=> s_q.snap_pend ##1 !s_q.snap_pend;
    endproperty
    a_snap_clears: assert property (p_snap_clears) else $error("snapshot bit did not clear"); // RULE2

    // release edge left out: the result is still being cleared there
    property p_err_follows;
        @(posedge clock) disable iff (srst)
        !srst |=> s_q.err == $past(ppm_count);
    endproperty
    a_err_follows: assert property (p_err_follows) else $error("error result not updated"); // RULE3

    property p_tap1;
        @(posedge clock) disable iff (srst)
        (bus.wr && bus.addr == rctr_pkg::ADDR_TOL_TAP1) |=> ##1 cfg.tap1_limit == $past(bus.wdata[4:0], 2);
    endproperty
    a_tap1: assert property (p_tap1) else $error("tap1 limit not applied"); // RULE4

    property p_eye_gate;
        @(posedge clock) disable iff (srst)
        (eye_fail && !s_q.eye_ref[6] && !s_q.irq_stat[1]) |=> !s_q.irq_stat[1];
    endproperty
    a_eye_gate: assert property (p_eye_gate) else $error("eye event while disabled"); // RULE5

    property p_eye_set;
        @(posedge clock) disable iff (srst)
        (eye_fail && s_q.eye_ref[6]) |=> s_q.irq_stat[1];
    endproperty
    a_eye_set: assert property (p_eye_set) else $error("eye event lost"); // RULE5

    property p_range;
        @(posedge clock) disable iff (srst)
        s_q.eye_ref[2] |=> cfg.stop_value == $past(range_start) - {3'h0, $past(s_q.eye_ref[1:0])} - 5'h01;
    endproperty
    a_range: assert property (p_range) else $error("stop value wrong"); // RULE8

    property p_status_ro;
        @(posedge clock) disable iff (srst)
        (bus.wr && bus.addr == rctr_pkg::ADDR_LEQ_STAT) |=> s_q.leq == $past(leq_status);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status written"); // RULE9

    property p_scale;
        @(posedge clock) disable iff (srst)
        (s_q.tol_tap1[7:6] == 2'h2) |=> cfg.tol_scaled == {$past(tol_base), 1'b0};
    endproperty
    a_scale: assert property (p_scale) else $error("tolerance scale wrong"); // RULE1

    property p_tol_plain;
        @(posedge clock) disable iff (srst)
        (!srst && s_q.tol_tap1[7:6] == 2'h0) |=> cfg.tol_scaled == {1'b0, $past(tol_base)};
    endproperty
    a_tol_plain: assert property (p_tol_plain) else $error("unscaled tolerance wrong"); // RULE1

    property p_tol_plus;
        @(posedge clock) disable iff (srst)
        (!srst && s_q.tol_tap1[7:6] == 2'h1)
            |=> cfg.tol_scaled == {1'b0, $past(tol_base)} + {6'h00, $past(tol_base[3:1])};
    endproperty
    a_tol_plus: assert property (p_tol_plus) else $error("tolerance plus part wrong"); // RULE1

    property p_tol_both;
        @(posedge clock) disable iff (srst)
        (!srst && s_q.tol_tap1[7:6] == 2'h3)
            |=> cfg.tol_scaled == {$past(tol_base), 1'b0} + {6'h00, $past(tol_base[3:1])};
    endproperty
    a_tol_both: assert property (p_tol_both) else $error("doubled tolerance plus part wrong"); // RULE1

    property p_snap_done;
        @(posedge clock) disable iff (srst)
        s_q.snap_pend |=> s_q.irq_stat[0];
    endproperty
    a_snap_done: assert property (p_snap_done) else $error("snapshot done not flagged"); // RULE2

    property p_snap_once;
        @(posedge clock) disable iff (srst)
        (s_q.snap_pend && !(bus.wr && bus.addr == rctr_pkg::ADDR_TOL_TAP1 && bus.wdata[5]))
            |=> !s_q.snap_pend;
    endproperty
    a_snap_once: assert property (p_snap_once) else $error("snapshot pending too long"); // RULE2

    property p_snap_rd;
        @(posedge clock) disable iff (srst)
        (s_q.snap_pend && bus.rd && bus.addr == rctr_pkg::ADDR_TOL_TAP1) |=> rdata[5];
    endproperty
    a_snap_rd: assert property (p_snap_rd) else $error("pending snapshot not visible"); // RULE2

    property p_err_rd;
        @(posedge clock) disable iff (srst)
        (bus.rd && bus.addr == rctr_pkg::ADDR_ERR_HI) |=> rdata == $past(s_q.err[15:8]);
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("error high byte read wrong"); // RULE2

    // ------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------

    property p_tap1_rst;
        @(posedge clock)
        srst |=> s_q.tol_tap1 == rctr_pkg::RST_TOL_TAP1;
    endproperty
    a_tap1_rst: assert property (p_tap1_rst) else $error("tap1 limit reset wrong"); // RULE4

    property p_ref_rst;
        @(posedge clock)
        srst |=> s_q.eye_ref == rctr_pkg::RST_EYE_REF;
    endproperty
    a_ref_rst: assert property (p_ref_rst) else $error("reference mode reset wrong"); // RULE6

    property p_stat_rst;
        @(posedge clock)
        srst |=> s_q.leq == rctr_pkg::RST_STATUS && s_q.feq == rctr_pkg::RST_STATUS;
    endproperty
    a_stat_rst: assert property (p_stat_rst) else $error("status reset wrong"); // RULE9

    // ------------------------------------------------------------
    // config and read-back checks
    // ------------------------------------------------------------

    property p_tap1_cfg;
        @(posedge clock) disable iff (srst)
        !srst |=> cfg.tap1_limit == $past(s_q.tol_tap1[4:0]);
    endproperty
    a_tap1_cfg: assert property (p_tap1_cfg) else $error("tap1 limit output wrong"); // RULE4

    property p_eye_cfg;
        @(posedge clock) disable iff (srst)
        !srst |=> cfg.eye_irq_enable == $past(s_q.eye_ref[6]);
    endproperty
    a_eye_cfg: assert property (p_eye_cfg) else $error("eye enable output wrong"); // RULE5

    property p_irq_pin;
        @(posedge clock) disable iff (srst)
        !srst |=> irq == $past(|(s_q.irq_stat & s_q.irq_mask));
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong"); // RULE5

    property p_ref_cfg;
        @(posedge clock) disable iff (srst)
        !srst |=> cfg.ref_mode == $past(s_q.eye_ref[5:4]);
    endproperty
    a_ref_cfg: assert property (p_ref_cfg) else $error("reference mode output wrong"); // RULE6

    property p_ov_cfg;
        @(posedge clock) disable iff (srst)
        !srst |=> cfg.range_override == $past(s_q.eye_ref[2]);
    endproperty
    a_ov_cfg: assert property (p_ov_cfg) else $error("override output wrong"); // RULE7

    // field ignored while the override is off
    property p_ov_off;
        @(posedge clock) disable iff (srst)
        (!srst && !s_q.eye_ref[2]) |=> cfg.stop_value == $past(range_start) - DEFAULT_RANGE;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("default range not used"); // RULE7

    property p_feq_ro;
        @(posedge clock) disable iff (srst)
        (bus.wr && bus.addr == rctr_pkg::ADDR_FEQ_STAT) |=> s_q.feq == $past(feq_status);
    endproperty
    a_feq_ro: assert property (p_feq_ro) else $error("feedback status written"); // RULE9

    property p_leq_rd;
        @(posedge clock) disable iff (srst)
        (bus.rd && bus.addr == rctr_pkg::ADDR_LEQ_STAT) |=> rdata == $past(s_q.leq);
    endproperty
    a_leq_rd: assert property (p_leq_rd) else $error("linear status read wrong"); // RULE9

    c_snap: cover property (@(posedge clock) s_q.snap_pend);
    c_eye: cover property (@(posedge clock) s_q.irq_stat[1]);
    c_tol: cover property (@(posedge clock) s_q.tol_tap1[7:6] == 2'h3);
    c_irq: cover property (@(posedge clock) irq);
    c_ov: cover property (@(posedge clock) cfg.range_override);

endmodule

`default_nettype wire

/* File: verif/rctr_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module rctr_regs_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    rctr_pkg::rctr_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] tol_base = 8'hB6;
    logic [4:0] range_start = 5'h1A;
    logic [15:0] ppm_count = 16'h1234;
    logic eye_fail = 1'b0;
    logic [7:0] leq_status = 8'h00;
    logic [7:0] feq_status = 8'h00;
    rctr_pkg::rctr_cfg_t cfg;
    logic irq;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] d;
    logic [8:0] e;

    rctr_regs u_dut (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
        .tol_base(tol_base), .range_start(range_start), .ppm_count(ppm_count),
        .eye_fail(eye_fail), .leq_status(leq_status), .feq_status(feq_status),
        .cfg(cfg), .irq(irq));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // each driving task waits a fresh edge first, so no signal is driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata;
    endtask

    // cfg lags the register by one cycle
    task automatic lag();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic pulse_eye();
        @(posedge clock);
        eye_fail <= 1'b1;
        @(posedge clock);
        eye_fail <= 1'b0;
        lag();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(8'h35); chk("tol_tap1", d, 8'h1F);
        rd(8'h36); chk("eye_ref", d, 8'h31);
        chk("tap1_limit", cfg.tap1_limit, 5'h1F);
        chk("ref_mode", cfg.ref_mode, 2'h3);
        chk("irq", irq, 1'b0);
        rd(8'h37); chk("leq_stat", d, 8'h00);
        rd(8'h38); chk("feq_stat", d, 8'h00);
        @(posedge clock);
        leq_status <= 8'h5A;
        feq_status <= 8'hA5;
        // read-only status bytes only ever written with zero
        wr(8'h37, 8'h00);
        wr(8'h38, 8'h00);
        rd(8'h37); chk("leq_src", d, 8'h5A);
        rd(8'h38); chk("feq_src", d, 8'hA5);
        rd(8'h40); chk("unmapped", d, 8'h00);
    endtask

    task automatic t_tol();
        for (int c = 0; c < 4; c++) begin
            wr(8'h35, {c[1:0], 1'b0, 5'h0A + 5'(c)});
            lag();
            e = {1'b0, tol_base};
            if (c[1]) e = e << 1;
            if (c[0]) e = e + {6'h00, tol_base[3:1]};
            chk("tol_scaled", cfg.tol_scaled, e);
            chk("tap1_limit", cfg.tap1_limit, 5'h0A + 5'(c));
            rd(8'h35); chk("tol_rd", d, {c[1:0], 1'b0, 5'h0A + 5'(c)});
        end
    endtask

    task automatic t_range();
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 4; r++) begin
                // reserved bits 7 and 3 kept zero
                wr(8'h36, {2'b00, m[1:0], 2'b01, r[1:0]});
                lag();
                chk("ref_mode", cfg.ref_mode, m[1:0]);
                chk("override", cfg.range_override, 1'b1);
                chk("stop", cfg.stop_value, range_start - 5'(r + 1));
            end
        end
        wr(8'h36, 8'h31);
        lag();
        chk("override", cfg.range_override, 1'b0);
        chk("stop_default", cfg.stop_value, range_start - 5'h02);
        wr(8'h36, 8'h33);
        lag();
        chk("stop_ignored", cfg.stop_value, range_start - 5'h02);
    endtask

    task automatic t_snap();
        wr(8'hF1, 8'h01);
        wr(8'h35, 8'h3F);
        repeat (3) @(posedge clock);
        rd(8'h35); chk("snap_clr", d, 8'h1F);
        rd(8'h3B); chk("err_lo", d, 8'h34);
        rd(8'h3C); chk("err_hi", d, 8'h12);
        chk("irq", irq, 1'b1);
        @(posedge clock);
        ppm_count <= 16'h5678;
        rd(8'hF0); chk("irq_stat", d, 8'h01);
        wr(8'hF0, 8'h01);
        lag();
        chk("irq", irq, 1'b0);
        rd(8'h3B); chk("err_track", d, 8'h78);
        // masked event must not reach the pin
        wr(8'hF1, 8'h00);
        wr(8'h35, 8'h3F);
        lag();
        rd(8'hF0); chk("irq_stat", d, 8'h01);
        chk("irq", irq, 1'b0);
        wr(8'hF0, 8'h01);
    endtask

    task automatic t_eye();
        wr(8'hF1, 8'h02);
        pulse_eye();
        rd(8'hF0); chk("eye_off", d, 8'h00);
        chk("irq", irq, 1'b0);
        wr(8'h36, 8'h71);
        lag();
        chk("eye_en", cfg.eye_irq_enable, 1'b1);
        pulse_eye();
        rd(8'hF0); chk("eye_on", d, 8'h02);
        chk("irq", irq, 1'b1);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_tol();
        t_range();
        t_snap();
        t_eye();
        stop_test();
    end
endmodule
`default_nettype wire
